// file: hw/sfpf_defs.vh
// Constants for the serial flash pin front end.
// Assumes inclusion by bare name from the hw/ files.
`ifndef SFPF_DEFS_VH
`define SFPF_DEFS_VH
// Array geometry
`define SFPF_ADDR_W 21
`define SFPF_PAGE_BYTES 256
`define SFPF_PAGE_COUNT 8192
`define SFPF_SECTOR_COUNT 512
`define SFPF_HALF_BLOCK_COUNT 64
`define SFPF_BLOCK_COUNT 32
`define SFPF_PAGES_PER_SECTOR 16
`define SFPF_PAGES_PER_HALF 128
`define SFPF_PAGES_PER_BLOCK 256
// Address field positions
`define SFPF_SECTOR_LSB 12
`define SFPF_HALF_LSB 15
`define SFPF_BLOCK_LSB 16
`define SFPF_ADDR_MSB 20
// Lane width codes
`define SFPF_LANES_1 2'h0
`define SFPF_LANES_2 2'h1
`define SFPF_LANES_4 2'h2
// Erase kinds
`define SFPF_ERASE_SECTOR 2'h0
`define SFPF_ERASE_HALF 2'h1
`define SFPF_ERASE_BLOCK 2'h2
`define SFPF_ERASE_CHIP 2'h3
`endif

// file: hw/sfpf_region.v
// Protected-region and erase-unit address decode.
// Assumes protection bits are stable, same-clock inputs.
`timescale 1ns/100ps
`include "sfpf_defs.vh"
module sfpf_region (
  input wire clk_in,
  input wire rstn_in,
  input wire [20:0] addr_in,
  input wire [1:0] erase_kind_in,
  input wire protect_complement_bit_in,
  input wire small_unit_protect_bit_in,
  input wire top_bottom_select_bit_in,
  input wire [2:0] protect_range_bits_in,
  output reg protected_out,
  output reg [8:0] sector_out,
  output reg [5:0] half_out,
  output reg [4:0] block_out
);
  reg [5:0] span;
  reg [5:0] unit;
  reg hit;
  // Range size in 64KB blocks (or in 4KB sectors when small units chosen)
  always @* begin
    span = 6'h00;
    unit = 6'h00;
    hit = 1'b0;
    if (protect_range_bits_in == 3'h7) begin
      span = 6'h20;
    end else if (protect_range_bits_in != 3'h0) begin
      span = small_unit_protect_bit_in ? (6'h01 << (protect_range_bits_in - 3'h1)) :
        (6'h01 << (protect_range_bits_in - 3'h1));
    end
    // Small units cap at 8 sectors; whole-array span is the 7 code
    if (small_unit_protect_bit_in && protect_range_bits_in != 3'h7) begin
      unit = top_bottom_select_bit_in ? {3'h0, addr_in[14:12]} : {3'h0, ~addr_in[14:12]};
      hit = (addr_in[20:15] == (top_bottom_select_bit_in ? 6'h00 : 6'h3F)) &&
        (unit < (span > 6'h08 ? 6'h08 : span));
    end else begin
      unit = top_bottom_select_bit_in ? {1'b0, addr_in[20:16]} : {1'b0, ~addr_in[20:16]};
      hit = unit < span;
    end
  end
  // Registered decode; a whole erase of the chip counts as hit by any range
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      protected_out <= 1'b0;
      sector_out <= 9'h000;
      half_out <= 6'h00;
      block_out <= 5'h00;
    end else begin
      protected_out <= protect_complement_bit_in ^
        ((erase_kind_in == `SFPF_ERASE_CHIP) ? (span != 6'h00) : hit);
      sector_out <= addr_in[`SFPF_ADDR_MSB:`SFPF_SECTOR_LSB];
      half_out <= addr_in[`SFPF_ADDR_MSB:`SFPF_HALF_LSB];
      block_out <= addr_in[`SFPF_ADDR_MSB:`SFPF_BLOCK_LSB];
    end
  end
endmodule

// file: hw/sfpf_front_end.v
// Pin-level front end of a serial flash: lane shifting, select, pause.
// Assumes the serial clock and pins are asynchronous to clk_in and
// toggle no faster than a quarter of clk_in.
`timescale 1ns/100ps
`include "sfpf_defs.vh"
module sfpf_front_end #(
  parameter PAGE_BYTES = `SFPF_PAGE_BYTES,
  parameter PAGE_COUNT = `SFPF_PAGE_COUNT
) (
  input wire clk_in,
  input wire rstn_in,
  input wire serial_clk_in,
  input wire chip_sel_n_in,
  input wire io_line_0_in,
  input wire io_line_1_in,
  input wire io_line_2_in,
  input wire io_line_3_in,
  output reg io_line_0_out,
  output reg io_line_1_out,
  output reg io_line_2_out,
  output reg io_line_3_out,
  output reg io_line_0_oe_n_out,
  output reg io_line_1_oe_n_out,
  output reg io_line_2_oe_n_out,
  output reg io_line_3_oe_n_out,
  input wire quad_enable_bit_in,
  input wire four_line_command_mode_in,
  input wire [1:0] lanes_in,
  input wire drive_phase_in,
  input wire [7:0] tx_byte_in,
  input wire [1:0] status_protect_bits_in,
  input wire protect_complement_bit_in,
  input wire small_unit_protect_bit_in,
  input wire top_bottom_select_bit_in,
  input wire [2:0] protect_range_bits_in,
  input wire [20:0] op_addr_in,
  input wire [1:0] erase_kind_in,
  input wire [8:0] prog_count_in,
  output reg [7:0] rx_byte_out,
  output reg rx_valid_out,
  output reg tx_take_out,
  output reg selected_out,
  output reg paused_out,
  output reg frame_end_out,
  output reg lanes_refused_out,
  output reg status_write_ok_out,
  output reg region_protected_out,
  output reg prog_len_ok_out,
  output reg [8:0] sector_index_out,
  output reg [5:0] half_index_out,
  output reg [4:0] block_index_out
);
  // Two-flop synchronisers, first stage read only by the second
  reg [6:0] sync1_r;
  reg [6:0] sync2_r;
  reg clk_d_r;
  reg armed_r;
  reg sel_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_in_r;
  reg [7:0] shift_out_r;
  reg [2:0] out_cnt_r;
  reg [1:0] lanes_r;
  wire sclk_s = sync2_r[0];
  wire csn_s = sync2_r[1];
  wire [3:0] io_s = sync2_r[5:2];
  wire pause_n_s = sync2_r[6];
  wire rise = sclk_s & ~clk_d_r;
  wire fall = ~sclk_s & clk_d_r;
  wire prot_pin_n = io_s[2];
  wire [8:0] sec_w;
  wire [5:0] half_w;
  wire [4:0] blk_w;
  wire prot_w;

  // Lanes per step; four-lane use needs quad enable, two lanes do not
  function [3:0] lane_step;
    input [1:0] code;
    begin
      case (code)
        `SFPF_LANES_2: lane_step = 4'h2;
        `SFPF_LANES_4: lane_step = 4'h4;
        default: lane_step = 4'h1;
      endcase
    end
  endfunction

  wire want_quad = (lanes_in == `SFPF_LANES_4) | four_line_command_mode_in;
  wire quad_ok = quad_enable_bit_in;
  wire [1:0] eff_lanes = four_line_command_mode_in ? `SFPF_LANES_4 : lanes_in;
  // Pause exists only without quad enable, otherwise pin is lane 3
  wire pause_act = ~quad_enable_bit_in & ~pause_n_s;
  wire [3:0] step = lane_step(lanes_r);
  wire [2:0] bits_per = step[2:0];

  sfpf_region u_region (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .addr_in(op_addr_in),
    .erase_kind_in(erase_kind_in),
    .protect_complement_bit_in(protect_complement_bit_in),
    .small_unit_protect_bit_in(small_unit_protect_bit_in),
    .top_bottom_select_bit_in(top_bottom_select_bit_in),
    .protect_range_bits_in(protect_range_bits_in),
    .protected_out(prot_w),
    .sector_out(sec_w),
    .half_out(half_w),
    .block_out(blk_w)
  );

  // Pin synchronisers; select resets low so reset never counts as a high select
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_r <= 7'h7C;
      sync2_r <= 7'h7C;
    end else begin
      sync1_r <= {io_line_3_in, io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in,
        chip_sel_n_in, serial_clk_in};
      sync2_r <= sync1_r;
    end
  end

  // Shift engine; edges only matter while selected and not paused
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_d_r <= 1'b0;
      armed_r <= 1'b0;
      sel_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      out_cnt_r <= 3'h0;
      shift_in_r <= 8'h00;
      shift_out_r <= 8'h00;
      lanes_r <= `SFPF_LANES_1;
      rx_byte_out <= 8'h00;
      rx_valid_out <= 1'b0;
      tx_take_out <= 1'b0;
      frame_end_out <= 1'b0;
      lanes_refused_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      tx_take_out <= 1'b0;
      frame_end_out <= 1'b0;
      // Mode 0 and 3 both idle-safe: edge tracking runs always
      clk_d_r <= sclk_s;
      if (csn_s) begin
        armed_r <= 1'b1;
        if (sel_r) begin
          frame_end_out <= 1'b1;
        end
        sel_r <= 1'b0;
      end else if (!sel_r && armed_r) begin
        sel_r <= 1'b1;
        bit_cnt_r <= 3'h0;
        out_cnt_r <= 3'h0;
        // Unqualified quad request drops back to one lane
        lanes_refused_out <= want_quad & ~quad_ok;
        lanes_r <= (want_quad & ~quad_ok) ? `SFPF_LANES_1 : eff_lanes;
        shift_out_r <= tx_byte_in;
      end else if (sel_r && !pause_act) begin
        // Counters hold across a pause so the transfer resumes in place
        if (rise && !drive_phase_in) begin
          case (lanes_r)
            `SFPF_LANES_2: shift_in_r <= {shift_in_r[5:0], io_s[1:0]};
            `SFPF_LANES_4: shift_in_r <= {shift_in_r[3:0], io_s};
            default: shift_in_r <= {shift_in_r[6:0], io_s[0]};
          endcase
          bit_cnt_r <= bit_cnt_r + bits_per;
          if (bit_cnt_r + bits_per == 3'h0) begin
            rx_valid_out <= 1'b1;
            case (lanes_r)
              `SFPF_LANES_2: rx_byte_out <= {shift_in_r[5:0], io_s[1:0]};
              `SFPF_LANES_4: rx_byte_out <= {shift_in_r[3:0], io_s};
              default: rx_byte_out <= {shift_in_r[6:0], io_s[0]};
            endcase
          end
        end
        if (fall && drive_phase_in) begin
          out_cnt_r <= out_cnt_r + bits_per;
          if (out_cnt_r + bits_per == 3'h0) begin
            shift_out_r <= tx_byte_in;
            tx_take_out <= 1'b1;
          end else begin
            shift_out_r <= shift_out_r << bits_per;
          end
        end
      end
    end
  end

  // Output lanes and enables; enables low while driving
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_line_0_out <= 1'b0;
      io_line_1_out <= 1'b0;
      io_line_2_out <= 1'b0;
      io_line_3_out <= 1'b0;
      io_line_0_oe_n_out <= 1'b1;
      io_line_1_oe_n_out <= 1'b1;
      io_line_2_oe_n_out <= 1'b1;
      io_line_3_oe_n_out <= 1'b1;
    end else begin
      io_line_0_oe_n_out <= 1'b1;
      io_line_1_oe_n_out <= 1'b1;
      io_line_2_oe_n_out <= 1'b1;
      io_line_3_oe_n_out <= 1'b1;
      io_line_0_out <= 1'b0;
      io_line_1_out <= 1'b0;
      io_line_2_out <= 1'b0;
      io_line_3_out <= 1'b0;
      // Floating whenever deselected, paused or in input phase
      if (sel_r && !csn_s && !pause_act && drive_phase_in) begin
        case (lanes_r)
          `SFPF_LANES_2: begin
            io_line_1_out <= shift_out_r[7];
            io_line_0_out <= shift_out_r[6];
            io_line_1_oe_n_out <= 1'b0;
            io_line_0_oe_n_out <= 1'b0;
          end
          `SFPF_LANES_4: begin
            {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} <=
              shift_out_r[7:4];
            io_line_0_oe_n_out <= 1'b0;
            io_line_1_oe_n_out <= 1'b0;
            io_line_2_oe_n_out <= 1'b0;
            io_line_3_oe_n_out <= 1'b0;
          end
          default: begin
            io_line_1_out <= shift_out_r[7];
            io_line_1_oe_n_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Status, protection and geometry results
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      selected_out <= 1'b0;
      paused_out <= 1'b0;
      status_write_ok_out <= 1'b0;
      region_protected_out <= 1'b0;
      prog_len_ok_out <= 1'b0;
      sector_index_out <= 9'h000;
      half_index_out <= 6'h00;
      block_index_out <= 5'h00;
    end else begin
      selected_out <= sel_r & ~csn_s;
      paused_out <= sel_r & ~csn_s & pause_act;
      // Hardware protection only while the pin is a protect pin
      status_write_ok_out <= ~(status_protect_bits_in == 2'h1 &&
        !quad_enable_bit_in && !prot_pin_n);
      region_protected_out <= prot_w;
      // One page at most per program, 1 to 256 bytes
      prog_len_ok_out <= (prog_count_in != 9'h000) &&
        (prog_count_in <= PAGE_BYTES[8:0]);
      sector_index_out <= sec_w;
      half_index_out <= half_w;
      block_index_out <= blk_w;
    end
  end
endmodule

// file: dv/sfpf_monitor.sv
// Checker for the flash pin front end, bound to its top module.
// Assumes pins reach the core 3 clk_in cycles after they move.
`timescale 1ns/100ps
module sfpf_monitor (
  input wire clk_in,
  input wire rstn_in,
  input wire chip_sel_n_in,
  input wire io_line_2_in,
  input wire io_line_3_in,
  input wire io_line_1_oe_n_out,
  input wire io_line_2_oe_n_out,
  input wire io_line_3_oe_n_out,
  input wire quad_enable_bit_in,
  input wire [1:0] lanes_in,
  input wire [1:0] status_protect_bits_in,
  input wire protect_complement_bit_in,
  input wire [2:0] protect_range_bits_in,
  input wire [20:0] op_addr_in,
  input wire [8:0] prog_count_in,
  input wire rx_valid_out,
  input wire selected_out,
  input wire paused_out,
  input wire frame_end_out,
  input wire lanes_refused_out,
  input wire status_write_ok_out,
  input wire region_protected_out,
  input wire prog_len_ok_out,
  input wire [8:0] sector_index_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Long enough for the synchroniser and output register
  sequence cs_idle; chip_sel_n_in [*6]; endsequence
  sequence addr_set; $stable(op_addr_in) [*4]; endsequence
  chk_desel_float: assert property (
    cs_idle |-> io_line_1_oe_n_out && io_line_2_oe_n_out && io_line_3_oe_n_out)
    else $error("output driven while deselected");
  chk_rx_selected: assert property (rx_valid_out |-> selected_out)
    else $error("byte captured while not selected");
  chk_desel_time: assert property ($rose(chip_sel_n_in) |-> ##[2:6] !selected_out)
    else $error("select not dropped");
  chk_frame_pulse: assert property (frame_end_out |=> !frame_end_out && !selected_out)
    else $error("frame end not a single pulse");
  chk_quad_refuse: assert property (
    $rose(selected_out) && !quad_enable_bit_in && lanes_in == 2'h2 |-> ##[0:2] lanes_refused_out)
    else $error("quad request accepted without enable");
  chk_lanes_kept: assert property (
    !quad_enable_bit_in [*8] |-> io_line_2_oe_n_out && io_line_3_oe_n_out)
    else $error("protect or pause pin driven");
  chk_pause_float: assert property (
    (!chip_sel_n_in && !io_line_3_in && !quad_enable_bit_in) [*5] |-> io_line_1_oe_n_out)
    else $error("output driven while paused");
  chk_pause_flag: assert property (
    (!chip_sel_n_in && !io_line_3_in && !quad_enable_bit_in && selected_out) [*5]
    |-> paused_out)
    else $error("pause not reported");
  chk_status_block: assert property (
    (status_protect_bits_in == 2'h1 && !quad_enable_bit_in && !io_line_2_in) [*5]
    |-> !status_write_ok_out)
    else $error("status write allowed while protected");
  chk_prog_limit: assert property (
    ($stable(prog_count_in) && prog_count_in != 9'h000) [*4]
    |-> prog_len_ok_out == (prog_count_in <= 9'h100))
    else $error("program length verdict wrong");
  chk_sector_index: assert property (addr_set |-> sector_index_out == op_addr_in[20:12])
    else $error("sector index wrong");
  chk_region_all: assert property (
    (protect_range_bits_in == 3'h7 && !protect_complement_bit_in) [*4] ##0 addr_set
    |-> region_protected_out)
    else $error("full range not protected");
endmodule
bind sfpf_front_end sfpf_monitor i_sfpf_monitor (.*);

// file: dv/sfpf_host.sv
// Host controller model: serial clock, select and io lanes, mode 0.
// Assumes the bench resolves each io wire from both parties.
`timescale 1ns/100ps
module sfpf_host (
  input wire [3:0] io_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_out,
  output logic [3:0] io_en_out
);
  // Select low from power-up on purpose; protect and pause idle high
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b0;
    io_out = 4'hC;
    io_en_out = 4'hD;
  end
  // Clock idles low at select edges
  task automatic sel(input logic v);
    #300 cs_n_out = v;
    #300;
  endtask
  // n bits per clock, highest lane is MSB; brk pauses mid-byte
  task automatic xfer(input logic [7:0] d, input int n, input logic [3:0] en,
                      input bit brk, output logic [7:0] q);
    io_en_out = en;
    for (int i = 0; i < 8; i += n) begin
      if (brk && i == 4) begin
        io_out[3] = 1'b0;
        #400;
        repeat (2) begin
          io_out[0] = ~io_out[0];
          #200 sclk_out = 1'b1;
          #200 sclk_out = 1'b0;
        end
        #400 io_out[3] = 1'b1;
        #400;
      end
      io_out = (n == 4) ? d[7:4] : (n == 2) ? {io_out[3:2], d[7:6]} : {io_out[3:1], d[7]};
      d = d << n;
      #200 sclk_out = 1'b1;
      q = (q << n) | ((n == 4) ? io_in : (n == 2) ? io_in[1:0] : io_in[1]);
      #200 sclk_out = 1'b0;
    end
    // Hand lanes back to protect and pause duty
    io_out = 4'hC;
    io_en_out = 4'hD;
  endtask
endmodule

// file: dv/sfpf_front_end_tb.sv
// Self-checking bench for the flash pin front end.
// Assumes the host model owns the link pins; bench owns the rest.
`timescale 1ns/100ps
module sfpf_front_end_tb;
  logic clk_in, rstn_in, quad_enable_bit_in, four_line_command_mode_in, drive_phase_in;
  logic protect_complement_bit_in, small_unit_protect_bit_in, top_bottom_select_bit_in;
  logic [1:0] lanes_in, status_protect_bits_in, erase_kind_in;
  logic [2:0] protect_range_bits_in;
  logic [7:0] tx_byte_in, rx_byte_out, q;
  logic [8:0] prog_count_in, sector_index_out;
  logic [20:0] op_addr_in;
  logic [5:0] half_index_out;
  logic [4:0] block_index_out;
  logic io_line_0_out, io_line_1_out, io_line_2_out, io_line_3_out;
  logic io_line_0_oe_n_out, io_line_1_oe_n_out, io_line_2_oe_n_out, io_line_3_oe_n_out;
  logic rx_valid_out, tx_take_out, selected_out, paused_out, frame_end_out;
  logic lanes_refused_out, status_write_ok_out, region_protected_out, prog_len_ok_out;
  wire serial_clk_in, chip_sel_n_in, io_line_0_in, io_line_1_in, io_line_2_in, io_line_3_in;
  wire [3:0] hd, he, lvl;
  wire [3:0] oe_n = {io_line_3_oe_n_out, io_line_2_oe_n_out, io_line_1_oe_n_out,
                     io_line_0_oe_n_out};
  wire [3:0] dv = {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out};
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int pz_cnt = 0;
  // Released wires show the inverse of the host's last value
  assign lvl = (~oe_n & dv) | (oe_n & he & hd) | (oe_n & ~he & ~hd);
  assign {io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in} = lvl;
  sfpf_front_end i_sfpf_front_end (.*);
  sfpf_host i_sfpf_host (.io_in(lvl), .sclk_out(serial_clk_in), .cs_n_out(chip_sel_n_in),
                         .io_out(hd), .io_en_out(he));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Byte count and hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (rx_valid_out === 1'b1)
      rx_cnt++;
    if (tx_take_out === 1'b1)
      tx_cnt++;
    if (paused_out === 1'b1)
      pz_cnt++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One whole frame: select, one byte, deselect
  task automatic run(input logic [7:0] d, input int n, input logic [3:0] en,
                     input bit brk, input bit refd);
    i_sfpf_host.sel(1'b0);
    wt(6);
    check(selected_out, 1'b1);
    check(lanes_refused_out, refd);
    i_sfpf_host.xfer(d, n, en, brk, q);
    wt(6);
    i_sfpf_host.sel(1'b1);
    wt(6);
    check(oe_n, 4'hF);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rstn_in = 1'b0;
    quad_enable_bit_in = 1'b0;
    four_line_command_mode_in = 1'b0;
    drive_phase_in = 1'b0;
    protect_complement_bit_in = 1'b0;
    small_unit_protect_bit_in = 1'b0;
    top_bottom_select_bit_in = 1'b0;
    lanes_in = 2'h0;
    status_protect_bits_in = 2'h0;
    erase_kind_in = 2'h0;
    protect_range_bits_in = 3'h0;
    tx_byte_in = 8'h3C;
    prog_count_in = 9'h001;
    op_addr_in = 21'h000000;
    wt(20);
    rstn_in = 1'b1;
    // Select low since power-up: the byte must be ignored
    i_sfpf_host.xfer(8'hA5, 1, 4'hD, 1'b0, q);
    wt(8);
    check(rx_cnt, 0);
    check(selected_out, 1'b0);
    i_sfpf_host.sel(1'b1);
    run(8'hA5, 1, 4'hD, 1'b0, 1'b0);
    check(rx_byte_out, 8'hA5);
    drive_phase_in = 1'b1;
    run(8'h00, 1, 4'hD, 1'b0, 1'b0);
    check(q, 8'h3C);
    check(tx_cnt, 1);
    drive_phase_in = 1'b0;
    lanes_in = 2'h1;
    run(8'hC3, 2, 4'hF, 1'b0, 1'b0);
    check(rx_byte_out, 8'hC3);
    // Quad and four-line: taken with enable set, refused without
    for (int m = 0; m < 4; m++) begin
      quad_enable_bit_in = !m[1];
      four_line_command_mode_in = m[0];
      lanes_in = m[0] ? 2'h0 : 2'h2;
      if (m == 1)
        lanes_in = 2'h2;
      run(8'h5A + m, m[1] ? 1 : 4, m[1] ? 4'hD : 4'hF, 1'b0, m[1]);
      check(rx_byte_out, 8'h5A + m);
    end
    four_line_command_mode_in = 1'b0;
    lanes_in = 2'h0;
    run(8'hE7, 1, 4'hD, 1'b1, 1'b0);
    check(rx_byte_out, 8'hE7);
    check(pz_cnt != 0, 1'b1);
    // Protect pin blocks status writes only while it is a pin
    status_protect_bits_in = 2'h1;
    for (int m = 0; m < 3; m++) begin
      quad_enable_bit_in = m[1];
      i_sfpf_host.io_out[2] = m[0];
      wt(6);
      check(status_write_ok_out, m != 0);
    end
    quad_enable_bit_in = 1'b0;
    i_sfpf_host.io_out[2] = 1'b1;
    // Top block in range 1; complement swaps the verdict
    protect_range_bits_in = 3'h1;
    for (int i = 0; i < 4; i++) begin
      op_addr_in = i[0] ? 21'h1F0000 : 21'h14F000;
      protect_complement_bit_in = i[1];
      wt(4);
      check(region_protected_out, i[0] ^ i[1]);
      check(sector_index_out, op_addr_in[20:12]);
      check(half_index_out, op_addr_in[20:15]);
      check(block_index_out, op_addr_in[20:16]);
    end
    protect_complement_bit_in = 1'b0;
    protect_range_bits_in = 3'h7;
    wt(4);
    check(region_protected_out, 1'b1);
    for (int c = 256; c < 258; c++) begin
      prog_count_in = c;
      wt(4);
      check(prog_len_ok_out, c == 256);
    end
    wrap_up();
  end
endmodule
